// ===== hdl/nvsc_host.sv
// Functional notes
// - Address held steady across whole write
// - Output enable kept high during writes
// - Write strobe held high during power-up load
// - Sequence steps are reads, one per step
`timescale 1ns/1ps
module nvsc_host
    import nvsc_pkg::*;
#(
    parameter int PU_CYC   = nvsc_pkg::POWERUP_LOAD_CYC,
    parameter int SAVE_CYC = nvsc_pkg::NV_SAVE_CYC,
    parameter int LOAD_CYC = nvsc_pkg::NV_LOAD_CYC
)(
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      power_good,
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire nvsc_pkg::nvsc_cmd_t       req_cmd,
    input  wire logic [nvsc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [nvsc_pkg::DATA_W-1:0] req_wdata,
    output logic                           rsp_valid,
    output logic [nvsc_pkg::DATA_W-1:0]    rsp_rdata,
    output logic [nvsc_pkg::ADDR_W-1:0]    mem_addr,
    output logic                           chip_en_n,
    output logic                           out_en_n,
    output logic                           write_en_n,
    input  wire logic [nvsc_pkg::DATA_W-1:0] io_bus_i,
    output logic [nvsc_pkg::DATA_W-1:0]    io_bus_o,
    output logic                           io_bus_oe_n,
    input  wire logic                      store_req_n_i,
    output logic                           store_req_n_o,
    output logic                           store_req_n_oe_n,
    input  wire logic                      hw_save_req,
    output logic                           nv_busy
);
    import nvsc_pkg::*;

    nvsc_state_t               st_q, st_d;
    logic [WAIT_W-1:0]         cnt_q, cnt_d;
    logic [2:0]                step_q, step_d;
    logic                      is_wr_q, is_wr_d;
    logic                      is_save_q, is_save_d;
    logic                      pu_done_q, pu_done_d;
    logic [ADDR_W-1:0]         addr_q, addr_d;
    logic [DATA_W-1:0]         wdata_q, wdata_d;
    logic [DATA_W-1:0]         rdata_q, rdata_d;
    logic                      rvld_q, rvld_d;
    logic                      ce_q, ce_d, we_q, we_d, oe_q, oe_d, drv_q, drv_d, hsb_q, hsb_d;
    logic [2:0]                hsb_s_q, pg_s_q;
    logic [DATA_W-1:0]         io_s1_q, io_s2_q;
    logic                      hsb_low, pg_ok;
    logic                      hsb_low_q, hsb_low_d, pg_ok_q, pg_ok_d;
    logic                      hw_q, hw_d;
    logic [SEQ_W-1:0]          seq_addr;

    // Pin levels change only once second and third stages agree
    assign hsb_low_d = (hsb_s_q[1] == hsb_s_q[2]) ? ~hsb_s_q[2] : hsb_low_q;
    assign pg_ok_d   = (pg_s_q[1] == pg_s_q[2]) ? pg_s_q[2] : pg_ok_q;
    assign hsb_low   = hsb_low_q;
    assign pg_ok     = pg_ok_q;

    always_comb begin
        case (step_q)
            3'd0: seq_addr = SEQ_A0;
            3'd1: seq_addr = SEQ_A1;
            3'd2: seq_addr = SEQ_A2;
            3'd3: seq_addr = SEQ_A3;
            3'd4: seq_addr = SEQ_A4;
            default: seq_addr = is_save_q ? SEQ_SAVE : SEQ_LOAD;
        endcase
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        step_d = step_q;
        is_wr_d = is_wr_q;
        is_save_d = is_save_q;
        hw_d = hw_q;
        pu_done_d = pu_done_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rvld_d = 1'b0;
        ce_d = ce_q;
        we_d = we_q;
        oe_d = oe_q;
        drv_d = drv_q;
        hsb_d = 1'b1;
        req_ready = 1'b0;
        case (st_q)
            NVSC_IDLE: begin
                ce_d = 1'b1;
                we_d = 1'b1;
                oe_d = 1'b1;
                drv_d = 1'b0;
                if (!pg_ok) begin
                    pu_done_d = 1'b0;
                    cnt_d = '0;
                end else if (!pu_done_q) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q >= WAIT_W'(PU_CYC)) pu_done_d = 1'b1;
                end else if (hsb_low) begin
                    st_d = NVSC_HWREL;
                end else if (hw_save_req) begin
                    hw_d = 1'b1;
                    cnt_d = '0;
                    st_d = NVSC_HWREL;
                end else begin
                    req_ready = 1'b1;
                    if (req_valid) begin
                        addr_d = req_addr;
                        wdata_d = req_wdata;
                        cnt_d = '0;
                        if (req_cmd == NVSC_CMD_READ || req_cmd == NVSC_CMD_WRITE) begin
                            is_wr_d = (req_cmd == NVSC_CMD_WRITE);
                            st_d = NVSC_SETUP;
                        end else begin
                            is_save_d = (req_cmd == NVSC_CMD_SAVE);
                            is_wr_d = 1'b0;
                            step_d = 3'd0;
                            st_d = NVSC_SEQ;
                        end
                    end
                end
            end
            NVSC_SEQ: begin
                addr_d = {req_addr[ADDR_W-1], seq_addr};
                st_d = NVSC_SETUP;
            end
            NVSC_SETUP: begin
                cnt_d = cnt_q + 1'b1;
                oe_d = is_wr_q;
                drv_d = is_wr_q;
                if (cnt_q >= WAIT_W'(SETUP_CYC - 1)) begin
                    ce_d = 1'b0;
                    we_d = ~is_wr_q;
                    cnt_d = '0;
                    st_d = NVSC_STRB;
                end
            end
            NVSC_STRB: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= WAIT_W'(STROBE_CYC - 1)) begin
                    rdata_d = io_s2_q;
                    rvld_d = ~is_wr_q & (step_q == 3'd7);
                    ce_d = 1'b1;
                    we_d = 1'b1;
                    oe_d = 1'b1;
                    cnt_d = '0;
                    st_d = NVSC_RECOV;
                end
            end
            NVSC_RECOV: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= WAIT_W'(RECOV_CYC - 1)) begin
                    drv_d = 1'b0;
                    cnt_d = '0;
                    if (step_q == 3'd7 || is_wr_q) begin
                        step_d = 3'd7;
                        st_d = NVSC_IDLE;
                    end else if (step_q == 3'd5) begin
                        step_d = 3'd7;
                        st_d = NVSC_BUSY;
                    end else begin
                        step_d = step_q + 3'd1;
                        st_d = NVSC_SEQ;
                    end
                end
            end
            NVSC_BUSY: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= (is_save_q ? WAIT_W'(SAVE_CYC) : WAIT_W'(LOAD_CYC))) begin
                    cnt_d = '0;
                    st_d = NVSC_HWREL;
                end
            end
            NVSC_HWREL: begin
                cnt_d = cnt_q + 1'b1;
                if (hw_q) begin
                    // Pulse wide enough for the device, then let the synchroniser settle
                    hsb_d = 1'b0;
                    if (cnt_q >= WAIT_W'(RECOV_CYC - 1)) begin
                        hw_d = 1'b0;
                        cnt_d = '0;
                    end
                end else if (cnt_q >= WAIT_W'(RECOV_CYC) && !hsb_low) begin
                    cnt_d = '0;
                    st_d = NVSC_IDLE;
                end
            end
            default: st_d = NVSC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= NVSC_IDLE;
            cnt_q <= '0;
            step_q <= 3'd7;
            is_wr_q <= 1'b0;
            is_save_q <= 1'b0;
            pu_done_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= DATA_RST;
            rdata_q <= DATA_RST;
            rvld_q <= 1'b0;
            ce_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
            drv_q <= 1'b0;
            hsb_q <= 1'b1;
            hw_q <= 1'b0;
            hsb_low_q <= 1'b0;
            pg_ok_q <= 1'b0;
            hsb_s_q <= 3'b111;
            pg_s_q <= 3'b000;
            io_s1_q <= DATA_RST;
            io_s2_q <= DATA_RST;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
            is_wr_q <= is_wr_d;
            is_save_q <= is_save_d;
            pu_done_q <= pu_done_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rvld_q <= rvld_d;
            ce_q <= ce_d;
            we_q <= we_d;
            oe_q <= oe_d;
            drv_q <= drv_d;
            hsb_q <= hsb_d;
            hw_q <= hw_d;
            hsb_low_q <= hsb_low_d;
            pg_ok_q <= pg_ok_d;
            hsb_s_q <= {hsb_s_q[1:0], store_req_n_i};
            pg_s_q <= {pg_s_q[1:0], power_good};
            io_s1_q <= io_bus_i;
            io_s2_q <= io_s1_q;
        end
    end

    assign mem_addr = addr_q;
    assign chip_en_n = ce_q;
    assign write_en_n = we_q;
    assign out_en_n = oe_q;
    assign io_bus_o = wdata_q;
    assign io_bus_oe_n = ~drv_q;
    assign store_req_n_o = 1'b0;
    assign store_req_n_oe_n = hsb_q;
    assign rsp_valid = rvld_q;
    assign rsp_rdata = rdata_q;
    assign nv_busy = (st_q == NVSC_BUSY) || (st_q == NVSC_HWREL) || !pu_done_q;
endmodule : nvsc_host

// ===== hdl/nvsc_pkg.sv
package nvsc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEQ_W  = 14;
    localparam int CLK_MHZ = 250;
    // Bus cycle phase lengths in ns, rounded up to core_clk cycles
    localparam int SETUP_NS = 12;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOV_NS = 20;
    localparam int RECOV_CYC = (RECOV_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    localparam logic [SEQ_W-1:0] SEQ_A0   = 14'h0e38;
    localparam logic [SEQ_W-1:0] SEQ_A1   = 14'h31c7;
    localparam logic [SEQ_W-1:0] SEQ_A2   = 14'h03e0;
    localparam logic [SEQ_W-1:0] SEQ_A3   = 14'h3c1f;
    localparam logic [SEQ_W-1:0] SEQ_A4   = 14'h303f;
    localparam logic [SEQ_W-1:0] SEQ_SAVE = 14'h0fc0;
    localparam logic [SEQ_W-1:0] SEQ_LOAD = 14'h0c63;
    // Nonvolatile durations
    localparam int NV_SAVE_TIME_MS = 10;
    localparam int NV_LOAD_TIME_US = 20;
    localparam int POWERUP_LOAD_TIME_US = 550;
    localparam int NV_SAVE_CYC = NV_SAVE_TIME_MS * 1000 * CLK_MHZ;
    localparam int NV_LOAD_CYC = NV_LOAD_TIME_US * CLK_MHZ;
    localparam int POWERUP_LOAD_CYC = POWERUP_LOAD_TIME_US * CLK_MHZ;
    localparam int WAIT_W = 32;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [1:0] {
        NVSC_CMD_READ = 2'b00,
        NVSC_CMD_WRITE = 2'b01,
        NVSC_CMD_SAVE = 2'b10,
        NVSC_CMD_LOAD = 2'b11
    } nvsc_cmd_t;

    typedef enum logic [2:0] {
        NVSC_IDLE  = 3'b000,
        NVSC_SETUP = 3'b001,
        NVSC_STRB  = 3'b010,
        NVSC_RECOV = 3'b011,
        NVSC_SEQ   = 3'b100,
        NVSC_BUSY  = 3'b101,
        NVSC_HWREL = 3'b110
    } nvsc_state_t;
endpackage : nvsc_pkg

// ===== sim/nvsc_dev_model.sv
`timescale 1ns/1ps
module nvsc_dev_model
    import nvsc_pkg::*;
#(
    parameter int LOAD_NS    = 15000,
    parameter int SAVE_NS    = 30000,
    parameter int RESTORE_NS = 2000,
    parameter bit INHIBIT    = 1'b0
)(
    input  wire logic                        pwr_ok,
    input  wire logic [nvsc_pkg::ADDR_W-1:0] addr,
    input  wire logic                        chip_en_n,
    input  wire logic                        out_en_n,
    input  wire logic                        write_en_n,
    input  wire logic                        store_n,
    input  wire logic [nvsc_pkg::DATA_W-1:0] dq_in,
    output logic [nvsc_pkg::DATA_W-1:0]      dq_out,
    output logic                             dq_oe,
    output logic                             busy_n
);
    localparam logic [SEQ_W-1:0] SEQ_TAB [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [DATA_W-1:0] sram [0:32767];
    logic [DATA_W-1:0] nv   [0:32767];
    logic [SEQ_W-1:0]  seq_a;
    logic [ADDR_W-1:0] wr_a;
    logic [DATA_W-1:0] wr_d;
    logic [2:0]        step = 3'd0;
    logic              nv_run = 1'b0;
    logic              wr_arm = 1'b0;
    logic              written = 1'b0;
    initial begin
        busy_n = 1'b1;
        for (int i = 0; i < 32768; i++) nv[i] = i[7:0] ^ 8'h5a;
    end
    assign seq_a = addr[SEQ_W-1:0];
    assign dq_oe = !chip_en_n && !out_en_n && write_en_n && store_n && !nv_run;
    assign dq_out = sram[addr];
    // Write data tracks the bus while armed, stored when either strobe ends it
    always @(chip_en_n or write_en_n or dq_in or addr) begin
        if (!chip_en_n && !write_en_n && store_n && !nv_run) begin
            wr_arm = 1'b1;
            wr_a = addr;
            wr_d = dq_in;
        end else if (wr_arm) begin
            wr_arm = 1'b0;
            sram[wr_a] = wr_d;
            written = 1'b1;
        end
    end
    // Save holds the store line low as busy until done
    task automatic run_save();
        nv_run = 1'b1;
        busy_n = 1'b0;
        #SAVE_NS;
        for (int i = 0; i < 32768; i++) nv[i] = sram[i];
        written = 1'b0;
        nv_run = 1'b0;
        busy_n = 1'b1;
    endtask : run_save
    always @(posedge pwr_ok) begin
        nv_run = 1'b1;
        #RESTORE_NS;
        for (int i = 0; i < 32768; i++) sram[i] = nv[i];
        written = 1'b0;
        nv_run = 1'b0;
    end
    always @(negedge pwr_ok) if (!INHIBIT && written && !nv_run) run_save();
    always @(negedge store_n) if (busy_n && written && !nv_run) run_save();
    always @(negedge write_en_n) step = 3'd0;
    always @(negedge chip_en_n) begin
        if (!write_en_n || nv_run) step = 3'd0;
        else if (step == 3'd5 && seq_a == SEQ_LOAD) begin
            step = 3'd0;
            nv_run = 1'b1;
            for (int i = 0; i < 32768; i++) sram[i] = '0;
            #LOAD_NS;
            for (int i = 0; i < 32768; i++) sram[i] = nv[i];
            written = 1'b0;
            nv_run = 1'b0;
        end else if (step == 3'd5 && seq_a == SEQ_SAVE) begin
            step = 3'd0;
            run_save();
        end else if (step < 3'd5 && seq_a == SEQ_TAB[step]) step = step + 3'd1;
        else step = {2'b00, seq_a == SEQ_A0};
    end
endmodule : nvsc_dev_model

// ===== sim/nvsc_host_asserts.sv
`timescale 1ns/1ps
module nvsc_host_asserts
    import nvsc_pkg::*;
(
    input wire logic                          core_clk,
    input wire logic                          rst_n,
    input wire logic                          req_ready,
    input wire logic                          rsp_valid,
    input wire logic [nvsc_pkg::ADDR_W-1:0]   mem_addr,
    input wire logic                          chip_en_n,
    input wire logic                          out_en_n,
    input wire logic                          write_en_n,
    input wire logic                          io_bus_oe_n,
    input wire logic                          store_req_n_i,
    input wire logic                          nv_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    busy_no_write_a: assert property (nv_busy |-> write_en_n)
        else $error("write during busy");
    write_strobes_a: assert property (!write_en_n |-> !chip_en_n)
        else $error("write without chip enable");
    write_oe_high_a: assert property (!write_en_n |-> out_en_n)
        else $error("output enable low in write");
    write_drive_a: assert property (!write_en_n |-> !io_bus_oe_n)
        else $error("data not driven in write");
    read_no_drive_a: assert property (!out_en_n |-> io_bus_oe_n)
        else $error("bus driven in read");
    addr_hold_a: assert property (!write_en_n ##1 !write_en_n |-> $stable(mem_addr))
        else $error("address moved in write");
    rsp_after_read_a: assert property (rsp_valid |-> chip_en_n && !$past(chip_en_n))
        else $error("response not after strobe end");
    chip_pulse_a: assert property ($fell(chip_en_n) |-> !chip_en_n [*8])
        else $error("chip enable pulse short");
    busy_not_ready_a: assert property (nv_busy |-> !req_ready)
        else $error("ready while busy");
    hold_not_ready_a: assert property (!store_req_n_i |-> !req_ready)
        else $error("ready while store request low");
endmodule : nvsc_host_asserts

bind nvsc_host nvsc_host_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .io_bus_oe_n(io_bus_oe_n), .store_req_n_i(store_req_n_i), .nv_busy(nv_busy));

// ===== sim/nvsc_host_test.sv
`timescale 1ns/1ps
module nvsc_host_test;
    import nvsc_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, power_good = 1'b0, req_valid = 1'b0, hw_save_req = 1'b0;
    nvsc_cmd_t req_cmd = NVSC_CMD_READ;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, io_bus_i, io_bus_o, dev_q, last_q = '0;
    logic req_ready, rsp_valid, chip_en_n, out_en_n, write_en_n, io_bus_oe_n, nv_busy, dev_oe, busy_n;
    logic store_req_n_i, store_req_n_o, store_req_n_oe_n;
    int err_total = 0, checks = 0;
    logic [31:0] rng = 32'd83767;
    logic [DATA_W-1:0] exp_q [$];
    logic [DATA_W-1:0] wd [8];
    logic [ADDR_W-1:0] wa [8];
    always #2 core_clk = ~core_clk;
    // Released bus shows the inverse of its last level
    assign io_bus_i = !io_bus_oe_n ? io_bus_o : dev_oe ? dev_q : ~last_q;
    assign store_req_n_i = (store_req_n_oe_n | store_req_n_o) & busy_n;
    always @(posedge core_clk) last_q <= io_bus_i;
    nvsc_host #(.PU_CYC(1000), .SAVE_CYC(2500), .LOAD_CYC(1500)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .power_good(power_good), .req_valid(req_valid),
        .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .chip_en_n(chip_en_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n), .io_bus_i(io_bus_i), .io_bus_o(io_bus_o),
        .io_bus_oe_n(io_bus_oe_n), .store_req_n_i(store_req_n_i), .store_req_n_o(store_req_n_o),
        .store_req_n_oe_n(store_req_n_oe_n), .hw_save_req(hw_save_req), .nv_busy(nv_busy));
    nvsc_dev_model #(.LOAD_NS(3000), .SAVE_NS(5000), .RESTORE_NS(2000), .INHIBIT(1'b0)) dev (.pwr_ok(power_good),
        .addr(mem_addr), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .store_n(store_req_n_i), .dq_in(io_bus_i), .dq_out(dev_q), .dq_oe(dev_oe), .busy_n(busy_n));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp8
    task automatic cmp1(input string nm, input logic e, input logic g);
        cmp8(nm, {7'h00, e}, {7'h00, g});
    endtask : cmp1
    task automatic req(input nvsc_cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(negedge core_clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_addr = a;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 10000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 10000) cmp1("req_ready", 1'b1, req_ready);
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask : req
    task automatic hw_pulse();
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        hw_save_req = 1'b1;
        @(negedge core_clk);
        hw_save_req = 1'b0;
    endtask : hw_pulse
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        req(NVSC_CMD_READ, a, 8'h00);
    endtask : rd
    task automatic report_and_stop();
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    always @(negedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) cmp1("rsp_valid", 1'b0, rsp_valid);
            else cmp8("rsp_rdata", exp_q.pop_front(), rsp_rdata);
        end
    end
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (50) @(negedge core_clk);
        cmp1("req_ready", 1'b0, req_ready);
        power_good = 1'b1;
        repeat (900) @(negedge core_clk);
        cmp1("req_ready", 1'b0, req_ready);
        rd(15'h1234, 8'h34 ^ 8'h5a);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            wa[i] = (i == 0) ? 15'h0000 : (i == 7) ? 15'h7fff : {rng[ADDR_W-1:3], i[2:0]};
            wd[i] = rng[30:23];
            req(NVSC_CMD_WRITE, wa[i], wd[i]);
        end
        for (int i = 7; i >= 0; i--) rd(wa[i], wd[i]);
        req(NVSC_CMD_SAVE, 15'h0000, 8'h00);
        repeat (300) @(negedge core_clk);
        cmp1("nv_busy", 1'b1, nv_busy);
        cmp1("store_req_n_i", 1'b0, store_req_n_i);
        cmp1("req_ready", 1'b0, req_ready);
        req(NVSC_CMD_WRITE, wa[0], ~wd[0]);
        req(NVSC_CMD_LOAD, 15'h4000, 8'h00);
        repeat (300) @(negedge core_clk);
        cmp1("nv_busy", 1'b1, nv_busy);
        cmp1("req_ready", 1'b0, req_ready);
        for (int i = 0; i < 8; i++) rd(wa[i], wd[i]);
        hw_pulse();
        repeat (30) @(negedge core_clk);
        cmp1("nv_busy", 1'b0, nv_busy);
        rng = xs(rng);
        req(NVSC_CMD_WRITE, wa[0], rng[7:0]);
        hw_pulse();
        repeat (30) @(negedge core_clk);
        cmp1("nv_busy", 1'b1, nv_busy);
        req(NVSC_CMD_WRITE, wa[0], ~rng[7:0]);
        req(NVSC_CMD_LOAD, 15'h0000, 8'h00);
        rd(wa[0], rng[7:0]);
        repeat (40) @(negedge core_clk);
        report_and_stop();
    end
endmodule : nvsc_host_test
